// ### src/pbmc_map.svh
// timing and field constants for the push-button message control block
`ifndef PBMC_MAP_SVH
`define PBMC_MAP_SVH
`define PBMC_CLK_HZ 20000000
`define PBMC_DEB_US 20
`define PBMC_DEB_CYC ((`PBMC_DEB_US * (`PBMC_CLK_HZ / 1000000)))
`define PBMC_GERASE_MS 3000
`define PBMC_GERASE_CYC (`PBMC_GERASE_MS * (`PBMC_CLK_HZ / 1000))
`define PBMC_MSG_MS 100
`define PBMC_MSG_CYC (`PBMC_MSG_MS * (`PBMC_CLK_HZ / 1000))
`define PBMC_ERASE_CYC 16'h0040
`define PBMC_FEED_BIT 6
`define PBMC_LOUD_MAX 3'h0
`define PBMC_LOUD_MIN 3'h7
`define PBMC_PTR_W 4
`endif

// ### src/pbmc_pkg.sv
// types shared by the push-button message control block
package pbmc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_CAPTURE, ST_PLAY, ST_ERASE, ST_SKIP} pbmc_state_t;
   typedef struct packed {
      logic capture;
      logic audio_out;
      logic delete;
      logic skip;
      logic feed;
      logic loud;
   } pbmc_btn_t;
endpackage

// ### src/pbmc_top.sv
// push-button control logic: debounce, operation sequencing, ready/interrupt pin
`include "pbmc_map.svh"
module pbmc_debounce
#(
   parameter int CYC = 400,
   parameter bit BOTH = 1'b1
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_raw_n,
   output logic o_level_n
);
   logic [15:0] cnt_ff;
   logic lvl_ff;
   wire diff = i_raw_n != lvl_ff;
   // release edge passes at once when only the start is filtered
   wire fast = !BOTH && i_raw_n;
   wire done = cnt_ff == 16'(CYC - 1);
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_ff <= 16'h0000;
         lvl_ff <= 1'b1;
      end
      else
      begin
         cnt_ff <= (diff && !done && !fast) ? cnt_ff + 16'h0001 : 16'h0000;
         if (diff && (done || fast))
            lvl_ff <= i_raw_n;
      end
   end
   assign o_level_n = lvl_ff;
endmodule // pbmc_debounce

module pbmc_top
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_serial_mode,
   input wire logic [11:0] i_path_config,
   input wire logic i_cmd_done,
   input wire logic i_int_clear,
   input wire logic i_feed_through_button_n,
   input wire logic i_audio_out_trigger_n,
   input wire logic i_capture_trigger_n,
   input wire logic i_delete_trigger_n,
   input wire logic i_skip_next_trigger_n,
   input wire logic i_loudness_step_button_n,
   input wire logic [`PBMC_PTR_W-1:0] i_msg_count,
   output logic o_feed_through_on,
   output logic o_recording,
   output logic o_playing,
   output logic [`PBMC_PTR_W-1:0] o_msg_ptr,
   output logic o_erase_one,
   output logic o_erase_all,
   output logic [2:0] o_volume,
   output logic o_done_flag_out,
   output logic o_done_flag_oe_n
);
   // ************************************************************
   // reset release
   // ************************************************************
   logic [1:0] rst_sync_ff;
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   wire rst_n = rst_sync_ff[1];

   // ************************************************************
   // debounce
   // ************************************************************
   pbmc_pkg::pbmc_btn_t raw, lvl, lvl_d_ff;
   assign raw = '{capture: i_capture_trigger_n, audio_out: i_audio_out_trigger_n,
                  delete: i_delete_trigger_n, skip: i_skip_next_trigger_n,
                  feed: i_feed_through_button_n, loud: i_loudness_step_button_n};
   for (genvar g = 0; g < 6; g++)
   begin : g_deb
      pbmc_debounce #(.CYC(`PBMC_DEB_CYC), .BOTH(g != 5)) u_deb
      (
         .i_clk(i_sys_clk),
         .i_rst_n(rst_n),
         .i_raw_n(raw[g]),
         .o_level_n(lvl[g])
      );
   end
   wire [5:0] fall = lvl_d_ff & ~lvl;
   wire [5:0] rise = ~lvl_d_ff & lvl;
   wire f_loud = fall[0];
   wire f_skip = fall[2];
   wire f_del = fall[3];
   wire r_del = rise[3];
   wire f_play = fall[4];
   wire f_cap = fall[5];
   wire r_cap = rise[5];

   // ************************************************************
   // operation sequencer
   // ************************************************************
   pbmc_pkg::pbmc_state_t st_ff, nxt_st;
   logic [31:0] tmr_ff, nxt_tmr;
   logic [`PBMC_PTR_W-1:0] ptr_ff, nxt_ptr;
   logic del_all_ff, nxt_del_all;
   logic e1_ff, ea_ff, nxt_e1, nxt_ea;
   logic [2:0] loud_ff;
   logic loud_up_ff;
   logic int_ff;

   wire [`PBMC_PTR_W-1:0] last_ptr = (i_msg_count == '0) ? '0 : i_msg_count - 1'b1;
   wire [`PBMC_PTR_W-1:0] ptr_inc = (ptr_ff >= last_ptr) ? '0 : ptr_ff + 1'b1;
   wire at_edge = (ptr_ff == '0) || (ptr_ff == last_ptr);
   wire msg_end = tmr_ff >= 32'(`PBMC_MSG_CYC - 1);
   wire gl_hold = tmr_ff >= 32'(`PBMC_GERASE_CYC - 1);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_tmr = tmr_ff + 32'h1;
      nxt_ptr = ptr_ff;
      nxt_del_all = del_all_ff;
      nxt_e1 = 1'b0;
      nxt_ea = 1'b0;
      unique case (st_ff)
         pbmc_pkg::ST_IDLE:
         begin
            nxt_tmr = 32'h0;
            // one request at a time, capture first
            if (f_cap)
               nxt_st = pbmc_pkg::ST_CAPTURE;
            else if (f_play)
               nxt_st = pbmc_pkg::ST_PLAY;
            else if (f_del && at_edge)
            begin
               nxt_st = pbmc_pkg::ST_ERASE;
               nxt_del_all = 1'b0;
            end
            else if (f_skip)
               nxt_st = pbmc_pkg::ST_SKIP;
         end
         pbmc_pkg::ST_CAPTURE:
            if (r_cap || lvl.capture)
               nxt_st = pbmc_pkg::ST_IDLE;
         pbmc_pkg::ST_PLAY:
            if (f_play)
               nxt_st = pbmc_pkg::ST_IDLE;
            else if (f_skip)
            begin
               nxt_ptr = ptr_inc;
               nxt_tmr = 32'h0;
            end
            else if (msg_end)
            begin
               nxt_tmr = 32'h0;
               if (!lvl.audio_out)
                  nxt_ptr = ptr_inc;
               else
                  nxt_st = pbmc_pkg::ST_IDLE;
            end
         pbmc_pkg::ST_ERASE:
            if (!del_all_ff && !lvl.delete && gl_hold)
               nxt_del_all = 1'b1;
            else if (r_del || lvl.delete)
            begin
               nxt_st = pbmc_pkg::ST_IDLE;
               nxt_e1 = !del_all_ff;
               nxt_ea = del_all_ff;
               nxt_ptr = del_all_ff ? '0 : ((ptr_ff == '0) ? '0 : ptr_ff - 1'b1);
            end
         pbmc_pkg::ST_SKIP:
         begin
            nxt_ptr = ptr_inc;
            nxt_st = pbmc_pkg::ST_IDLE;
         end
         default:
            nxt_st = pbmc_pkg::ST_IDLE;
      endcase
      // in ST_PLAY, requests other than stop and skip fall through unused above
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= pbmc_pkg::ST_IDLE;
         tmr_ff <= 32'h0;
         ptr_ff <= '0;
         del_all_ff <= 1'b0;
         e1_ff <= 1'b0;
         ea_ff <= 1'b0;
         lvl_d_ff <= '1;
      end
      else
      begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         ptr_ff <= nxt_ptr;
         del_all_ff <= nxt_del_all;
         e1_ff <= nxt_e1;
         ea_ff <= nxt_ea;
         lvl_d_ff <= lvl;
      end
   end

   // ************************************************************
   // volume and ready/interrupt pin
   // ************************************************************
   wire at_min = loud_ff == `PBMC_LOUD_MIN;
   wire at_max = loud_ff == `PBMC_LOUD_MAX;
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loud_ff <= `PBMC_LOUD_MAX;
         loud_up_ff <= 1'b0;
         int_ff <= 1'b0;
      end
      else
      begin
         if (f_loud)
         begin
            // level 7 is quietest; bounce between the ends
            if ((!loud_up_ff && at_min) || (loud_up_ff && at_max))
            begin
               loud_up_ff <= !loud_up_ff;
               loud_ff <= at_min ? loud_ff - 3'h1 : loud_ff + 3'h1;
            end
            else
               loud_ff <= loud_up_ff ? loud_ff - 3'h1 : loud_ff + 3'h1;
         end
         // a completion in the clear cycle wins
         if (i_cmd_done)
            int_ff <= 1'b1;
         else if (i_int_clear)
            int_ff <= 1'b0;
      end
   end

   wire busy = st_ff != pbmc_pkg::ST_IDLE;
   wire pin_low = i_serial_mode ? int_ff : busy;
   assign o_done_flag_out = 1'b0;
   assign o_done_flag_oe_n = !pin_low;
   assign o_feed_through_on = i_serial_mode ? i_path_config[`PBMC_FEED_BIT]
                                            : !lvl.feed;
   assign o_recording = st_ff == pbmc_pkg::ST_CAPTURE;
   assign o_playing = st_ff == pbmc_pkg::ST_PLAY;
   assign o_msg_ptr = ptr_ff;
   assign o_erase_one = e1_ff;
   assign o_erase_all = ea_ff;
   assign o_volume = loud_ff;
endmodule // pbmc_top

// ### tb/pbmc_top_monitor.sv
// concurrent checks on the push-button control ports
module pbmc_top_monitor
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_serial_mode,
   input wire logic [11:0] i_path_config,
   input wire logic i_cmd_done,
   input wire logic i_int_clear,
   input wire logic i_capture_trigger_n,
   input wire logic i_loudness_step_button_n,
   input wire logic o_feed_through_on,
   input wire logic o_recording,
   input wire logic o_playing,
   input wire logic o_erase_one,
   input wire logic o_erase_all,
   input wire logic [2:0] o_volume,
   input wire logic o_done_flag_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   logic [9:0] cap_lo_ff;
   logic [9:0] loud_hi_ff;
   // saturating run lengths of the raw pins
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cap_lo_ff <= '0;
         loud_hi_ff <= '0;
      end
      else
      begin
         cap_lo_ff <= i_capture_trigger_n ? '0 : cap_lo_ff + {9'h0, ~&cap_lo_ff};
         loud_hi_ff <= !i_loudness_step_button_n ? '0 : loud_hi_ff + {9'h0, ~&loud_hi_ff};
      end
   end
   a_feed_serial: assert property (
      i_serial_mode |-> o_feed_through_on == i_path_config[6]) else $error("feed bit");
   a_busy_pin: assert property (
      !i_serial_mode && (o_recording || o_playing) |-> !o_done_flag_oe_n) else $error("busy");
   a_erase_excl: assert property (
      !(o_erase_one && o_erase_all)) else $error("two erases");
   a_erase_busy: assert property (
      !i_serial_mode && (o_erase_one || o_erase_all) |-> !$past(o_done_flag_oe_n))
      else $error("erase without busy pin");
   a_int_set: assert property (
      i_serial_mode && i_cmd_done |=> !o_done_flag_oe_n || !i_serial_mode) else $error("int");
   a_int_hold: assert property (
      i_serial_mode && !o_done_flag_oe_n && !i_int_clear |=> !o_done_flag_oe_n || !i_serial_mode)
      else $error("int dropped");
   a_int_clear: assert property (
      i_serial_mode && i_int_clear && !i_cmd_done |=> o_done_flag_oe_n || !i_serial_mode)
      else $error("clear");
   a_loud_quiet: assert property (
      loud_hi_ff > 10'h1f4 |-> $stable(o_volume)) else $error("volume moved");
   a_capture_filter: assert property (
      $rose(o_recording) |-> cap_lo_ff > 10'h18f) else $error("capture early");
   a_capture_end: assert property (
      o_recording && i_capture_trigger_n |-> ##[1:4] !o_recording) else $error("capture end");
   c_capture: cover property ($rose(o_recording));
   c_loud_turn: cover property (o_volume == 3'h6 && $past(o_volume) == 3'h7);
   c_erase: cover property (o_erase_one);
   c_stop: cover property ($fell(o_playing));
endmodule // pbmc_top_monitor

// ### tb/pbmc_button_bank.sv
// push-button bank: turns press requests into bouncing active-low pins
module pbmc_button_bank
(
   input wire logic i_clk,
   input wire logic [5:0] i_press,
   output pbmc_pkg::pbmc_btn_t o_btn_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] prev_ff = '0;
   logic [5:0] chg_ff = '0;
   logic [2:0] chat_ff = '0;
   initial o_btn_n = '1;
   // contacts chatter a few cycles per change, far shorter than the filter
   always @(posedge i_clk)
   begin
      prev_ff <= i_press;
      if (i_press != prev_ff) chg_ff <= i_press ^ prev_ff;
      chat_ff <= (i_press != prev_ff) ? 3'h6 : chat_ff - {2'h0, |chat_ff};
      o_btn_n <= chat_ff[0] ? ~i_press ^ chg_ff : ~i_press;
   end
endmodule // pbmc_button_bank

// ### tb/pbmc_top_tb.sv
// bench: drives buttons through the bank model and judges the ports
module pbmc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, ser = 1'b0, done = 1'b0, clr = 1'b0;
   logic [11:0] cfg = '0;
   logic [3:0] cnt = 4'h3;
   logic [5:0] prs = '0;
   pbmc_pkg::pbmc_btn_t b_n;
   logic feed_on, capturing, play, e1, ea, dout, oe_n;
   logic [3:0] ptr;
   logic [2:0] loud;
   int errors = 0, tests_run = 0, n_one = 0, n_all = 0;
   wire pin = oe_n ? 1'b1 : dout; // pull-up while released
   always #25 clk = ~clk;
   always @(posedge clk) if (e1 === 1'b1) n_one++;
   always @(posedge clk) if (ea === 1'b1) n_all++;
   pbmc_button_bank i_pbmc_button_bank (.i_clk(clk), .i_press(prs), .o_btn_n(b_n));
   pbmc_top i_pbmc_top (.i_sys_clk(clk), .i_arst_n(rst_n), .i_serial_mode(ser),
      .i_path_config(cfg), .i_cmd_done(done), .i_int_clear(clr),
      .i_feed_through_button_n(b_n.feed), .i_audio_out_trigger_n(b_n.audio_out),
      .i_capture_trigger_n(b_n.capture), .i_delete_trigger_n(b_n.delete),
      .i_skip_next_trigger_n(b_n.skip), .i_loudness_step_button_n(b_n.loud),
      .i_msg_count(cnt), .o_feed_through_on(feed_on), .o_recording(capturing),
      .o_playing(play), .o_msg_ptr(ptr), .o_erase_one(e1), .o_erase_all(ea), .o_volume(loud),
      .o_done_flag_out(dout), .o_done_flag_oe_n(oe_n));
   task wrap_up;
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [4:0] got, input logic [4:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // automatic: the timeout process waits through the same task concurrently
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // index: 0 loud, 1 feed, 2 skip, 3 delete, 4 play, 5 capture
   task automatic tap(input int b);
      prs[b] = 1'b1;
      cyc(450);
      prs[b] = 1'b0;
      cyc(450);
   endtask
   task t_feed;
      prs[1] = 1'b1;
      cyc(450);
      chk(5'(feed_on), 5'h01);
      ser = 1'b1;
      cyc(1);
      chk(5'(feed_on), 5'h00);
      cfg[6] = 1'b1;
      prs[1] = 1'b0;
      cyc(450);
      chk(5'(feed_on), 5'h01);
      ser = 1'b0;
      cfg = '0;
      cyc(1);
      chk(5'(feed_on), 5'h00);
   endtask
   task t_capture;
      prs[5] = 1'b1;
      cyc(300);
      chk(5'(capturing), 5'h00);
      cyc(150);
      chk(5'({capturing, oe_n}), 5'h02);
      tap(2);
      chk(5'(ptr), 5'h00);
      tap(4);
      chk(5'({capturing, play}), 5'h02);
      prs[5] = 1'b0;
      cyc(4);
      chk(5'(capturing), 5'h00);
      cyc(450);
      chk(5'(pin), 5'h01);
   endtask
   task t_skip;
      tap(2);
      chk({play, ptr}, 5'h01);
      tap(2);
      tap(2);
      chk(5'(ptr), 5'h00);
   endtask
   task t_del;
      tap(2);
      tap(3);
      chk(5'(n_one), 5'h00);
      tap(2);
      tap(3);
      chk(5'(n_one), 5'h01);
      chk(5'(n_all), 5'h00);
      chk(5'(ptr), 5'h01);
   endtask
   task t_play;
      tap(4);
      chk(5'({play, oe_n}), 5'h02);
      tap(2);
      chk({play, ptr}, 5'h12);
      tap(4);
      chk(5'(play), 5'h00);
   endtask
   task t_loud;
      for (int i = 1; i < 8; i++)
      begin
         tap(0);
         chk(5'(loud), i[4:0]);
      end
      tap(0);
      chk(5'(loud), 5'h06);
   endtask
   task t_int;
      ser = 1'b1;
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      cyc(20);
      chk(5'(pin), 5'h00);
      done = 1'b1;
      clr = 1'b1;
      cyc(1);
      done = 1'b0;
      clr = 1'b0;
      cyc(2);
      chk(5'(pin), 5'h00);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
      chk(5'(pin), 5'h01);
      ser = 1'b0;
   endtask
   initial
   begin
      cyc(3);
      rst_n = 1'b1;
      cyc(3);
      chk(5'({pin, loud}), 5'h08);
      t_feed;
      t_capture;
      t_skip;
      t_del;
      t_play;
      t_loud;
      t_int;
      wrap_up;
   end
   initial
   begin
      cyc(60000);
      errors++;
      wrap_up;
   end
endmodule // pbmc_top_tb
bind pbmc_top pbmc_top_monitor i_pbmc_top_monitor
(
   .i_sys_clk(i_sys_clk),
   .i_arst_n(i_arst_n),
   .i_serial_mode(i_serial_mode),
   .i_path_config(i_path_config),
   .i_cmd_done(i_cmd_done),
   .i_int_clear(i_int_clear),
   .i_capture_trigger_n(i_capture_trigger_n),
   .i_loudness_step_button_n(i_loudness_step_button_n),
   .o_feed_through_on(o_feed_through_on),
   .o_recording(o_recording),
   .o_playing(o_playing),
   .o_erase_one(o_erase_one),
   .o_erase_all(o_erase_all),
   .o_volume(o_volume),
   .o_done_flag_oe_n(o_done_flag_oe_n)
);
